// file: common/bsx_consts.vh
`ifndef BSX_CONSTS_VH
`define BSX_CONSTS_VH
// Register lengths
`define BSX_BSR_LEN      80
`define BSX_IR_LEN       8
`define BSX_ID_LEN       32
// Instruction opcodes
`define BSX_OP_EXTEST    8'h00
`define BSX_OP_SAMPLE    8'h81
`define BSX_OP_CLAMP     8'h82
`define BSX_OP_HIGHZ     8'h03
`define BSX_OP_SAMP_IN   8'h41
`define BSX_OP_SAMP_OUT  8'h42
`define BSX_OP_EXT_OUT   8'h22
`define BSX_OP_IDCODE    8'hAA
`define BSX_OP_BYPASS    8'hFF
// Instruction capture value
`define BSX_IR_CAPTURE   8'h81
// Boundary bit positions
`define BSX_BIT_DIR0     79
`define BSX_BIT_OEN0     78
`define BSX_BIT_AEN0     77
`define BSX_BIT_BEN0     76
`define BSX_BIT_BYTE0_DIRECTION     75
`define BSX_BIT_OEN1     74
`define BSX_BIT_AEN1     73
`define BSX_BIT_BEN1     72
`define BSX_POS_AIN0     63
`define BSX_POS_AIN1     54
`define BSX_POS_BOUT0    45
`define BSX_POS_BOUT1    36
`define BSX_POS_BIN0     27
`define BSX_POS_BIN1     18
`define BSX_POS_AOUT0    9
`define BSX_POS_AOUT1    0
// Identification fields (arbitrary values)
`define BSX_ID_VERSION   4'h1
`define BSX_ID_ENTITY    6'h15
`define BSX_ID_PART      10'h2A5
`define BSX_ID_MAKER     11'h155
`endif

// file: verilog/bsx_transceiver.v
`timescale 1ns/1ns
`include "bsx_consts.vh"

module bsx_transceiver (
  // System clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // Scan port
  input  wire        tck,
  input  wire        tms,
  input  wire        tdi,
  output reg         tdo,
  output reg         tdo_oe,
  // Byte controls
  input  wire        byte0_direction,
  input  wire        byte1_direction,
  input  wire        byte0_output_enable_n,
  input  wire        byte1_output_enable_n,
  // Byte 0 pins
  input  wire [8:0]  byte0_a_port_i,
  output reg  [8:0]  byte0_a_port_o,
  output reg         byte0_a_port_oe,
  input  wire [8:0]  byte0_b_port_i,
  output reg  [8:0]  byte0_b_port_o,
  output reg         byte0_b_port_oe,
  // Byte 1 pins
  input  wire [8:0]  byte1_a_port_i,
  output reg  [8:0]  byte1_a_port_o,
  output reg         byte1_a_port_oe,
  input  wire [8:0]  byte1_b_port_i,
  output reg  [8:0]  byte1_b_port_o,
  output reg         byte1_b_port_oe
);

  // ----------------------------------------
  // TAP states
  // ----------------------------------------
  localparam [3:0] ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3;
  localparam [3:0] ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PAU_DR = 4'h6, ST_EX2_DR = 4'h7;
  localparam [3:0] ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'hA, ST_SH_IR = 4'hB;
  localparam [3:0] ST_EX1_IR = 4'hC, ST_PAU_IR = 4'hD, ST_EX2_IR = 4'hE, ST_UPD_IR = 4'hF;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  wire [42:0] raw_in = {tck, tms, tdi, byte0_direction, byte1_direction,
                        byte0_output_enable_n, byte1_output_enable_n,
                        byte0_a_port_i, byte0_b_port_i, byte1_a_port_i, byte1_b_port_i};
  reg  [42:0] meta_r;
  reg  [42:0] sync_r;
  reg         tck_d_r;

  // Two flops on every outside input, since none share our clock
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r  <= 43'h000_0000_0000;
      sync_r  <= 43'h000_0000_0000;
      tck_d_r <= 1'b0;
    end else begin
      meta_r  <= raw_in;
      sync_r  <= meta_r;
      tck_d_r <= sync_r[42];
    end
  end

  wire       tck_s  = sync_r[42];
  wire       tms_s  = sync_r[41];
  wire       tdi_s  = sync_r[40];
  wire       dir0_s = sync_r[39];
  wire       byte0_direction_s = sync_r[38];
  wire       oen0_s = sync_r[37];
  wire       oen1_s = sync_r[36];
  wire [8:0] a0_s   = sync_r[35:27];
  wire [8:0] b0_s   = sync_r[26:18];
  wire [8:0] a1_s   = sync_r[17:9];
  wire [8:0] b1_s   = sync_r[8:0];
  wire       tck_rise = tck_s & ~tck_d_r;
  wire       tck_fall = ~tck_s & tck_d_r;

  // ----------------------------------------
  // TAP controller
  // ----------------------------------------
  reg [3:0] st_r;
  reg [3:0] st_nxt;

  // Standard sixteen-state walk on TMS
  always @* begin
    case (st_r)
      ST_RESET:  st_nxt = tms_s ? ST_RESET  : ST_IDLE;
      ST_IDLE:   st_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: st_nxt = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: st_nxt = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  st_nxt = tms_s ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: st_nxt = tms_s ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: st_nxt = tms_s ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: st_nxt = tms_s ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: st_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: st_nxt = tms_s ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: st_nxt = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  st_nxt = tms_s ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: st_nxt = tms_s ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: st_nxt = tms_s ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: st_nxt = tms_s ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: st_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
      default:   st_nxt = ST_RESET;
    endcase
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      st_r <= ST_RESET;
    else if (tck_rise)
      st_r <= st_nxt;
  end

  // ----------------------------------------
  // Instruction register and decode
  // ----------------------------------------
  reg [7:0] ir_sh_r;
  reg [7:0] ir_r;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ir_sh_r <= `BSX_IR_CAPTURE;
      ir_r    <= `BSX_OP_IDCODE;
    end else if (st_r == ST_RESET) begin
      ir_r    <= `BSX_OP_IDCODE;
    end else if (tck_rise) begin
      case (st_r)
        ST_CAP_IR: ir_sh_r <= `BSX_IR_CAPTURE;
        ST_SH_IR:  ir_sh_r <= {tdi_s, ir_sh_r[7:1]};
        ST_UPD_IR: ir_r    <= ir_sh_r;
        default:   ir_r    <= ir_r;
      endcase
    end
  end

  // Decoded instruction classes
  wire op_extest  = (ir_r == `BSX_OP_EXTEST);
  wire op_sample  = (ir_r == `BSX_OP_SAMPLE);
  wire op_clamp   = (ir_r == `BSX_OP_CLAMP);
  wire op_highz   = (ir_r == `BSX_OP_HIGHZ);
  wire op_samp_in = (ir_r == `BSX_OP_SAMP_IN);
  wire op_samp_o  = (ir_r == `BSX_OP_SAMP_OUT);
  wire op_ext_out = (ir_r == `BSX_OP_EXT_OUT);
  wire op_idcode  = (ir_r == `BSX_OP_IDCODE);
  wire sel_bsr    = op_extest | op_sample | op_samp_in | op_samp_o | op_ext_out;
  wire sel_bypass = ~sel_bsr & ~op_idcode;
  wire drive_bsr  = op_extest | op_ext_out | op_clamp;

  // ----------------------------------------
  // Boundary capture vector
  // ----------------------------------------
  reg  [79:0] bsr_sh_r;
  reg  [79:0] bsr_up_r;
  reg  [79:0] cap_vec;
  wire [79:0] in_mask;
  wire [79:0] out_mask;
  reg  [8:0]  ao0, bo0, ao1, bo1;
  reg         aen0, ben0, aen1, ben1;
  integer     i;

  // Observe-only groups are inputs, others are output data and enable cells
  assign in_mask  = {2'b11, 2'b00, 2'b11, 2'b00, 18'h3_FFFF, 18'h0_0000,
                     18'h3_FFFF, 18'h0_0000};
  assign out_mask = ~in_mask;

  // Pack pins; lowest index sits highest in each group
  always @* begin
    cap_vec = 80'h0;
    cap_vec[`BSX_BIT_DIR0] = dir0_s;
    cap_vec[`BSX_BIT_OEN0] = oen0_s;
    cap_vec[`BSX_BIT_AEN0] = aen0;
    cap_vec[`BSX_BIT_BEN0] = ben0;
    cap_vec[`BSX_BIT_BYTE0_DIRECTION] = byte0_direction_s;
    cap_vec[`BSX_BIT_OEN1] = oen1_s;
    cap_vec[`BSX_BIT_AEN1] = aen1;
    cap_vec[`BSX_BIT_BEN1] = ben1;
    for (i = 0; i < 9; i = i + 1) begin
      cap_vec[`BSX_POS_AIN0 + 8 - i]  = a0_s[i];
      cap_vec[`BSX_POS_AIN1 + 8 - i]  = a1_s[i];
      cap_vec[`BSX_POS_BOUT0 + 8 - i] = bo0[i];
      cap_vec[`BSX_POS_BOUT1 + 8 - i] = bo1[i];
      cap_vec[`BSX_POS_BIN0 + 8 - i]  = b0_s[i];
      cap_vec[`BSX_POS_BIN1 + 8 - i]  = b1_s[i];
      cap_vec[`BSX_POS_AOUT0 + 8 - i] = ao0[i];
      cap_vec[`BSX_POS_AOUT1 + 8 - i] = ao1[i];
    end
  end

  // ----------------------------------------
  // Data registers
  // ----------------------------------------
  reg        byp_r;
  reg [31:0] id_r;
  wire [31:0] id_val = {`BSX_ID_VERSION, `BSX_ID_ENTITY, `BSX_ID_PART,
                        `BSX_ID_MAKER, 1'b1};

  // Sampling variants capture only their own cell group
  wire [79:0] cap_keep = op_samp_in ? out_mask : (op_samp_o ? in_mask : 80'h0);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bsr_sh_r <= 80'h0;
      bsr_up_r <= 80'h0;
      byp_r    <= 1'b0;
      id_r     <= 32'h0000_0000;
    end else if (tck_rise) begin
      if (st_r == ST_CAP_DR) begin
        byp_r <= 1'b0;
        id_r  <= id_val;
        if (sel_bsr)
          bsr_sh_r <= (cap_vec & ~cap_keep) | (bsr_sh_r & cap_keep);
      end else if (st_r == ST_SH_DR) begin
        byp_r <= tdi_s;
        id_r  <= {tdi_s, id_r[31:1]};
        if (sel_bsr)
          bsr_sh_r <= {tdi_s, bsr_sh_r[79:1]};
      end else if (st_r == ST_UPD_DR && sel_bsr) begin
        bsr_up_r <= bsr_sh_r;
      end
    end
  end

  // ----------------------------------------
  // Serial output on falling edge
  // ----------------------------------------
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe <= (st_r == ST_SH_DR) | (st_r == ST_SH_IR);
      if (st_r == ST_SH_IR)
        tdo <= ir_sh_r[0];
      else if (sel_bsr)
        tdo <= bsr_sh_r[0];
      else if (sel_bypass)
        tdo <= byp_r;
      else
        tdo <= id_r[0];
    end
  end

  // ----------------------------------------
  // Power-on disable latches
  // ----------------------------------------
  reg oen_d_r [0:1];
  reg hold_r  [0:1];
  integer k;

  // Released only by a high-to-low edge of the byte enable
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (k = 0; k < 2; k = k + 1) begin
        oen_d_r[k] <= 1'b0;
        hold_r[k]  <= 1'b1;
      end
    end else begin
      oen_d_r[0] <= oen0_s;
      oen_d_r[1] <= oen1_s;
      if (oen_d_r[0] & ~oen0_s)
        hold_r[0] <= 1'b0;
      if (oen_d_r[1] & ~oen1_s)
        hold_r[1] <= 1'b0;
    end
  end

  // ----------------------------------------
  // System path and output muxing
  // ----------------------------------------
  // Each byte looks only at its own direction and enable
  always @* begin
    aen0 = ~oen0_s & ~dir0_s & ~hold_r[0];
    ben0 = ~oen0_s &  dir0_s & ~hold_r[0];
    aen1 = ~oen1_s & ~byte0_direction_s & ~hold_r[1];
    ben1 = ~oen1_s &  byte0_direction_s & ~hold_r[1];
    ao0  = b0_s;
    bo0  = a0_s;
    ao1  = b1_s;
    bo1  = a1_s;
  end

  wire [8:0] up_bo0, up_bo1, up_ao0, up_ao1;
  genvar g;
  generate
    for (g = 0; g < 9; g = g + 1) begin : g_unpack
      assign up_bo0[g] = bsr_up_r[`BSX_POS_BOUT0 + 8 - g];
      assign up_bo1[g] = bsr_up_r[`BSX_POS_BOUT1 + 8 - g];
      assign up_ao0[g] = bsr_up_r[`BSX_POS_AOUT0 + 8 - g];
      assign up_ao1[g] = bsr_up_r[`BSX_POS_AOUT1 + 8 - g];
    end
  endgenerate

  // Registered pins; test modes override normal paths
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      byte0_a_port_o  <= 9'h000;
      byte0_b_port_o  <= 9'h000;
      byte1_a_port_o  <= 9'h000;
      byte1_b_port_o  <= 9'h000;
      byte0_a_port_oe <= 1'b0;
      byte0_b_port_oe <= 1'b0;
      byte1_a_port_oe <= 1'b0;
      byte1_b_port_oe <= 1'b0;
    end else if (op_highz) begin
      byte0_a_port_oe <= 1'b0;
      byte0_b_port_oe <= 1'b0;
      byte1_a_port_oe <= 1'b0;
      byte1_b_port_oe <= 1'b0;
    end else if (drive_bsr) begin
      byte0_a_port_o  <= up_ao0;
      byte0_b_port_o  <= up_bo0;
      byte1_a_port_o  <= up_ao1;
      byte1_b_port_o  <= up_bo1;
      byte0_a_port_oe <= bsr_up_r[`BSX_BIT_AEN0];
      byte0_b_port_oe <= bsr_up_r[`BSX_BIT_BEN0];
      byte1_a_port_oe <= bsr_up_r[`BSX_BIT_AEN1];
      byte1_b_port_oe <= bsr_up_r[`BSX_BIT_BEN1];
    end else begin
      byte0_a_port_o  <= ao0;
      byte0_b_port_o  <= bo0;
      byte1_a_port_o  <= ao1;
      byte1_b_port_o  <= bo1;
      byte0_a_port_oe <= aen0;
      byte0_b_port_oe <= ben0;
      byte1_a_port_oe <= aen1;
      byte1_b_port_oe <= ben1;
    end
  end

endmodule // bsx_transceiver

// file: dv/bsx_transceiver_assertions.sv
`timescale 1ns/1ns
module bsx_chk (
  // Clock, reset, scan
  input wire       clk_sys,
  input wire       rst_n,
  input wire       tck,
  input wire       tdo_oe,
  // Byte controls
  input wire       byte0_direction,
  input wire       byte1_direction,
  input wire       byte0_output_enable_n,
  input wire       byte1_output_enable_n,
  // Pins
  input wire [8:0] byte0_a_port_i,
  input wire [8:0] byte0_b_port_o,
  input wire       byte0_a_port_oe,
  input wire       byte0_b_port_oe,
  input wire [8:0] byte1_b_port_i,
  input wire [8:0] byte1_a_port_o,
  input wire       byte1_a_port_oe,
  input wire       byte1_b_port_oe
);
  // Normal mode is certain only before the first tck pulse
  reg quiet_r;
  reg hi0_r;
  reg hi1_r;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      quiet_r <= 1'b1;
      hi0_r   <= 1'b0;
      hi1_r   <= 1'b0;
    end else begin
      quiet_r <= quiet_r & ~tck;
      hi0_r   <= hi0_r | byte0_output_enable_n;
      hi1_r   <= hi1_r | byte1_output_enable_n;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_reset_float: assert property ($rose(rst_n) |-> !(byte0_a_port_oe | byte0_b_port_oe |
    byte1_a_port_oe | byte1_b_port_oe | tdo_oe)) else $error("pins drive at reset exit");
  a_latch_float0: assert property (quiet_r && !hi0_r |-> !byte0_a_port_oe && !byte0_b_port_oe)
    else $error("byte0 drives before enable edge");
  a_latch_float1: assert property (quiet_r && !hi1_r |-> !byte1_a_port_oe && !byte1_b_port_oe)
    else $error("byte1 drives before enable edge");
  a_enable_float0: assert property ((quiet_r && byte0_output_enable_n)[*6] |->
    !byte0_a_port_oe && !byte0_b_port_oe) else $error("byte0 drives while disabled");
  a_enable_float1: assert property ((quiet_r && byte1_output_enable_n)[*6] |->
    !byte1_a_port_oe && !byte1_b_port_oe) else $error("byte1 drives while disabled");
  a_atob_byte0: assert property ((quiet_r && hi0_r && !byte0_output_enable_n && byte0_direction
    && $stable(byte0_a_port_i))[*6] |-> byte0_b_port_oe && !byte0_a_port_oe
    && byte0_b_port_o == byte0_a_port_i) else $error("byte0 A to B wrong");
  a_btoa_byte1: assert property ((quiet_r && hi1_r && !byte1_output_enable_n && !byte1_direction
    && $stable(byte1_b_port_i))[*6] |-> byte1_a_port_oe && !byte1_b_port_oe
    && byte1_a_port_o == byte1_b_port_i) else $error("byte1 B to A wrong");
  a_tdo_quiet: assert property (quiet_r |-> !tdo_oe) else $error("tdo driven outside shift");
endmodule // bsx_chk

bind bsx_transceiver bsx_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .tck(tck),
  .tdo_oe(tdo_oe), .byte0_direction(byte0_direction), .byte1_direction(byte1_direction),
  .byte0_output_enable_n(byte0_output_enable_n), .byte1_output_enable_n(byte1_output_enable_n),
  .byte0_a_port_i(byte0_a_port_i), .byte0_b_port_o(byte0_b_port_o),
  .byte0_a_port_oe(byte0_a_port_oe), .byte0_b_port_oe(byte0_b_port_oe),
  .byte1_b_port_i(byte1_b_port_i), .byte1_a_port_o(byte1_a_port_o),
  .byte1_a_port_oe(byte1_a_port_oe), .byte1_b_port_oe(byte1_b_port_oe));

// file: dv/bsx_jtag_host.sv
`timescale 1ns/1ns
module bsx_jtag_host (
  // Scan pins
  output reg  tck,
  output reg  tms,
  output reg  tdi,
  input  wire tdo
);
  // tck stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One 320 ns tck period; tdo taken late in the low half, after it settles
  task step(input t, input d, output o);
    begin
      tms = t;
      tdi = d;
      #160;
      o = tdo;
      tck = 1'b1;
      #160;
      tck = 1'b0;
    end
  endtask
  // Plain TMS walk, LSB first; idle tdi toggles so no stale value is seen
  task walk(input [7:0] seq, input integer n);
    reg o;
    integer i;
    begin
      for (i = 0; i < n; i = i + 1)
        step(seq[i], ~tdi, o);
    end
  endtask
  // Scan from Run-Test/Idle back to Run-Test/Idle, LSB first
  task scan(input ir, input integer n, input [79:0] din, output [79:0] dout);
    reg o;
    integer i;
    begin
      dout = 80'h0;
      walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
      for (i = 0; i < n; i = i + 1) begin
        step(i == n - 1, din[i], o);
        dout[i] = o;
      end
      walk(8'h01, 2);
    end
  endtask
endmodule // bsx_jtag_host

// file: dv/tb.sv
`timescale 1ns/1ns
`include "bsx_consts.vh"
module tb;
  reg         clk_sys, rst_n, d0, d1, g0, g1;
  reg  [8:0]  xa0, xb0, xa1, xb1;
  reg  [31:0] seed;
  reg  [79:0] v, p, q, m;
  integer     fail_count, checks, cyc, k;
  wire        tck, tms, tdi, tdo, tdo_oe, a0_oe, b0_oe, a1_oe, b1_oe;
  wire [8:0]  a0_i, b0_i, a1_i, b1_i, a0_o, b0_o, a1_o, b1_o;
  // Wire level: design drive wins, else the bench's own value
  assign a0_i = a0_oe ? a0_o : xa0;
  assign b0_i = b0_oe ? b0_o : xb0;
  assign a1_i = a1_oe ? a1_o : xa1;
  assign b1_i = b1_oe ? b1_o : xb1;
  always #20 clk_sys = ~clk_sys;
  bsx_transceiver DUT (.clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .byte0_direction(d0), .byte1_direction(d1),
    .byte0_output_enable_n(g0), .byte1_output_enable_n(g1),
    .byte0_a_port_i(a0_i), .byte0_a_port_o(a0_o), .byte0_a_port_oe(a0_oe),
    .byte0_b_port_i(b0_i), .byte0_b_port_o(b0_o), .byte0_b_port_oe(b0_oe),
    .byte1_a_port_i(a1_i), .byte1_a_port_o(a1_o), .byte1_a_port_oe(a1_oe),
    .byte1_b_port_i(b1_i), .byte1_b_port_o(b1_o), .byte1_b_port_oe(b1_oe));
  bsx_jtag_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  function [31:0] lfsr(input [31:0] s);
    integer i;
    begin
      lfsr = s;
      for (i = 0; i < 32; i = i + 1)
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    end
  endfunction
  // Capture image of the observe-only cells
  function [79:0] bsr_exp(input a, b, c, e, input [8:0] p, q, r, s);
    integer i;
    begin
      bsr_exp = {a, b, 2'b00, c, e, 74'h0};
      for (i = 0; i < 9; i = i + 1) begin
        bsr_exp[71-i] = p[i];
        bsr_exp[62-i] = q[i];
        bsr_exp[35-i] = r[i];
        bsr_exp[26-i] = s[i];
      end
    end
  endfunction
  task chk(input logic [79:0] got, input logic [79:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk_sys);
      #1;
    end
  endtask
  task rnd;
    begin
      seed = lfsr(seed);
      {d0, d1, xa0, xb0, xa1} = seed[28:0];
      seed = lfsr(seed);
      xb1 = seed[8:0];
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // Hang guard, about twice the expected run
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      fail_count = fail_count + 1;
      close_out;
    end
  end
  initial begin
    {clk_sys, rst_n, d0, d1, g0, g1, xa0, xb0, xa1, xb1} = 42'h0;
    {fail_count, checks, cyc} = 0;
    seed = 32'h938f;
    tick(8);
    rst_n = 1'b1;
    tick(10);
    chk({a0_oe, b0_oe, a1_oe, b1_oe, tdo_oe}, 5'h00);
    g0 = 1'b1;
    tick(6);
    g0 = 1'b0;
    tick(8);
    chk({a0_oe, b0_oe, a1_oe, b1_oe}, 4'h8);
    g1 = 1'b1;
    tick(6);
    g1 = 1'b0;
    for (k = 0; k < 12; k = k + 1) begin
      rnd;
      tick(8);
      chk({a0_oe, b0_oe, d0 ? b0_o : a0_o}, {~d0, d0, d0 ? xa0 : xb0});
      chk({a1_oe, b1_oe, d1 ? b1_o : a1_o}, {~d1, d1, d1 ? xa1 : xb1});
    end
    g0 = 1'b1;
    tick(8);
    chk({a0_oe, b0_oe, a1_oe | b1_oe}, 3'h1);
    $display("test pins done");
    u_host.walk(8'h1F, 6);
    u_host.scan(1'b0, 32, 80'h0, v);
    chk(v[31:0], {`BSX_ID_VERSION, `BSX_ID_ENTITY, `BSX_ID_PART, `BSX_ID_MAKER, 1'b1});
    for (k = 0; k < 2; k = k + 1) begin
      u_host.scan(1'b1, 8, k ? 80'h5A : `BSX_OP_BYPASS, v);
      chk(v[7:0], `BSX_IR_CAPTURE);
      seed = lfsr(seed);
      u_host.scan(1'b0, 33, seed, v);
      chk(v[32:0], {seed, 1'b0});
    end
    $display("test scan registers done");
    g0 = 1'b0;
    u_host.scan(1'b1, 8, `BSX_OP_HIGHZ, v);
    tick(8);
    chk({a0_oe, b0_oe, a1_oe, b1_oe}, 4'h0);
    g0 = 1'b1;
    g1 = 1'b1;
    rnd;
    tick(8);
    u_host.walk(8'h1B, 6);
    // Output groups sit 18 cells below their input twins
    q = bsr_exp(1'b0, 1'b0, 1'b0, 1'b0, xa0, xa1, xb0, xb1) >> 18;
    p = q | {2'b00, 2'b11, 2'b00, 2'b10, 72'h0};
    m = bsr_exp(1'b1, 1'b1, 1'b1, 1'b1, 9'h1FF, 9'h1FF, 9'h1FF, 9'h1FF);
    u_host.scan(1'b0, 80, p, v);
    chk(v & m,
      bsr_exp(d0, g0, d1, g1, xa0, xa1, xb0, xb1));
    chk(v & ~m, q);
    $display("test sample done");
    // Preloaded cells drive the pins, then sample-in keeps them
    u_host.scan(1'b1, 8, `BSX_OP_EXTEST, v);
    tick(8);
    chk({a0_oe, b0_oe, a1_oe, b1_oe, a0_o, b0_o, a1_o, b1_o}, {4'hE, xb0, xa0, xb1, xa1});
    u_host.scan(1'b1, 8, `BSX_OP_SAMP_IN, v);
    tick(8);
    u_host.scan(1'b0, 80, 80'h0, v);
    chk(v, bsr_exp(d0, g0, d1, g1, xa0, xa1, xb0, xb1) | p);
    $display("test extest done");
    close_out;
  end
endmodule // tb
